// ===== common/sau_params.svh
// constants for the media integer unpack/add/sub/or/shift unit
// assumes: 32-bit instruction word, 64-bit media registers
`ifndef SAU_PARAMS_SVH
`define SAU_PARAMS_SVH
// instruction field positions
`define SAU_OPC_HI 31
`define SAU_OPC_LO 26
`define SAU_FMT_HI 25
`define SAU_FMT_LO 21
`define SAU_FT_HI 20
`define SAU_FT_LO 16
`define SAU_FS_HI 15
`define SAU_FS_LO 11
`define SAU_FD_HI 10
`define SAU_FD_LO 6
`define SAU_FN_HI 5
`define SAU_FN_LO 0
// major opcode of the media coprocessor group
`define SAU_COPROCESSOR_TWO_OPCODE 6'h12
// format field codes
`define SAU_FMT_UPB 5'h1a
`define SAU_FMT_UPH 5'h18
`define SAU_FMT_UPW 5'h1c
`define SAU_FMT_W 5'h1a
`define SAU_FMT_U 5'h18
`define SAU_FMT_D 5'h1b
`define SAU_FMT_OR 5'h1d
// function field codes
`define SAU_FN_UPK 6'h03
`define SAU_FN_UPW 6'h0b
`define SAU_FN_ADD 6'h0c
`define SAU_FN_SUB 6'h0d
`define SAU_FN_SLL 6'h0e
// word shift counts at or above this clear the result
`define SAU_SLL_LIM 64'h20
// reset values
`define SAU_RST_DATA 64'h0
`define SAU_RST_REG 5'h0
`endif

// ===== common/sau_pkg.sv
// types shared by the unpack/add/sub unit
// assumes: sau_params.svh holds the numeric constants
package sau_pkg;
   typedef enum logic [11:0] {
      OP_NOP  = 12'h001,
      OP_UPB  = 12'h002,
      OP_UPH  = 12'h004,
      OP_UPW  = 12'h008,
      OP_ADDW = 12'h010,
      OP_ADDU = 12'h020,
      OP_ADDD = 12'h040,
      OP_SUBW = 12'h080,
      OP_SUBU = 12'h100,
      OP_SUBD = 12'h200,
      OP_OR   = 12'h400,
      OP_SLL  = 12'h800
   } sau_op_type;

   typedef struct packed {
      logic sub;
      logic dbl;
      logic trap;
   } sau_arith_type;

   typedef struct packed {
      sau_op_type op;
      logic [4:0] fd;
   } sau_issue_type;

   function automatic logic [63:0] sau_sext_word(input logic [31:0] w);
      sau_sext_word = {{32{w[31]}}, w};
   endfunction : sau_sext_word
endpackage : sau_pkg

// ===== verilog/sau_unpack.sv
// low-order interleave of bytes, halfwords or words of two operands
// assumes: purely combinational, operands stable for the cycle
`timescale 1ns/10ps
module sau_unpack #(
   parameter int DW = 64
) (
   // operands
   input wire logic [DW-1:0] a_i,
   input wire logic [DW-1:0] b_i,
   input wire sau_pkg::sau_op_type sel_i,
   // result
   output logic [DW-1:0] res_o
);
   localparam int NB = DW / 16;
   localparam int NH = DW / 32;
   logic [DW-1:0] ub;
   logic [DW-1:0] uh;
   logic [DW-1:0] uw;

   generate
      if (DW != 64) begin : g_chk
         $error("sau_unpack serves 64-bit operands only");
      end
      for (genvar i = 0; i < NB; i++) begin : g_b
         assign ub[16*i +: 8] = a_i[8*i +: 8];
         assign ub[16*i+8 +: 8] = b_i[8*i +: 8];
      end
      for (genvar j = 0; j < NH; j++) begin : g_h
         assign uh[32*j +: 16] = a_i[16*j +: 16];
         assign uh[32*j+16 +: 16] = b_i[16*j +: 16];
      end
   endgenerate

   assign uw = {b_i[DW/2-1:0], a_i[DW/2-1:0]};

   // zero second operand gives zero extension for free, no trap path
   always_comb begin
      res_o = uw;
      if (sel_i == sau_pkg::OP_UPB) res_o = ub;
      else if (sel_i == sau_pkg::OP_UPH) res_o = uh;
   end
endmodule : sau_unpack

// ===== verilog/sau_addsub.sv
// shared adder for word and doubleword add/subtract with overflow
// assumes: word forms get sign-extended 32-bit operands
`timescale 1ns/10ps
module sau_addsub #(
   parameter int DW = 64
) (
   // operands and mode
   input wire logic [DW-1:0] a_i,
   input wire logic [DW-1:0] b_i,
   input wire sau_pkg::sau_arith_type mode_i,
   // result
   output logic [DW-1:0] res_o,
   output logic ovf_o
);
   localparam int WM = DW / 2 - 1;
   logic [DW-1:0] bx;
   logic [DW-1:0] sum;
   logic ovf_w;
   logic ovf_d;

   generate
      if (DW != 64) begin : g_chk
         $error("sau_addsub serves 64-bit operands only");
      end
   endgenerate

   // one carry chain; subtract is add of the inverted operand plus one
   assign bx = mode_i.sub ? ~b_i : b_i;
   assign sum = a_i + bx + {{(DW-1){1'b0}}, mode_i.sub};
   // word overflow taken on bit 31 of the same chain
   assign ovf_w = (a_i[WM] == bx[WM]) && (sum[WM] != a_i[WM]);
   assign ovf_d = (a_i[DW-1] == bx[DW-1]) && (sum[DW-1] != a_i[DW-1]);

   always_comb begin
      res_o = sau_pkg::sau_sext_word(sum[WM:0]);
      ovf_o = mode_i.trap & ovf_w;
      if (mode_i.dbl) begin
         res_o = sum;
         ovf_o = mode_i.trap & ovf_d;
      end
   end
endmodule : sau_addsub

// ===== verilog/sau_simd_unit.sv
// media integer slice: low unpack, add/sub, or, word shift left
// assumes: register file returns read data in the same cycle as the address
// Functional notes
// - byte unpack interleaves four low bytes
// - halfword unpack interleaves two low halfwords
// - word unpack: first low, second high
// - zero second operand zero-extends, never traps
// - trapping word add writes sign-extended sum
// - trapping word add detects 32-bit overflow
// - overflow traps and leaves destination unchanged
// - trapping doubleword add writes 64-bit sum
// - doubleword add/sub trap on 64-bit overflow
// - trapping word subtract, 32-bit overflow trap
// - trapping doubleword subtract writes difference
// - non-trapping word subtract never traps
// - non-trapping word add, sign-extended, no trap
// - or writes bitwise or, no trap
// - word shift left fills zeros
// - shift result sign-extended, zero when count>=32
`timescale 1ns/10ps
`include "sau_params.svh"
module sau_simd_unit #(
   parameter int DW = 64,
   parameter int RAW = 5
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // issue
   input wire logic ISSUE_VALID_I,
   input wire logic [31:0] INSTR_I,
   // register file read
   output logic RF_RD_EN_O,
   output logic [RAW-1:0] FS_ADDR_O,
   output logic [RAW-1:0] FT_ADDR_O,
   input wire logic [DW-1:0] FS_DATA_I,
   input wire logic [DW-1:0] FT_DATA_I,
   // write back and exception
   output logic WB_VALID_O,
   output logic [RAW-1:0] WB_ADDR_O,
   output logic [DW-1:0] WB_DATA_O,
   output logic OVF_EXC_O
);
   generate
      if (DW != 64 || RAW != 5) begin : g_chk
         $error("sau_simd_unit needs DW=64 and RAW=5");
      end
   endgenerate

   sau_pkg::sau_op_type dec_op;
   sau_pkg::sau_issue_type iss_r;
   sau_pkg::sau_arith_type mode;
   logic [5:0] opc;
   logic [4:0] fmt;
   logic [5:0] fn;
   logic [DW-1:0] unp_res;
   logic [DW-1:0] ars_res;
   logic ars_ovf;
   logic [31:0] sll_w;
   logic [DW-1:0] res_nxt;
   logic ovf_nxt;
   logic vld_nxt;

   assign opc = INSTR_I[`SAU_OPC_HI:`SAU_OPC_LO];
   assign fmt = INSTR_I[`SAU_FMT_HI:`SAU_FMT_LO];
   assign fn = INSTR_I[`SAU_FN_HI:`SAU_FN_LO];

   // instructions of other units decode to no-op and are dropped
   always_comb begin
      dec_op = sau_pkg::OP_NOP;
      if (ISSUE_VALID_I && opc == `SAU_COPROCESSOR_TWO_OPCODE) begin
         unique case ({fmt, fn})
            {`SAU_FMT_UPB, `SAU_FN_UPK}: dec_op = sau_pkg::OP_UPB;
            {`SAU_FMT_UPH, `SAU_FN_UPK}: dec_op = sau_pkg::OP_UPH;
            {`SAU_FMT_UPW, `SAU_FN_UPW}: dec_op = sau_pkg::OP_UPW;
            {`SAU_FMT_W, `SAU_FN_ADD}: dec_op = sau_pkg::OP_ADDW;
            {`SAU_FMT_U, `SAU_FN_ADD}: dec_op = sau_pkg::OP_ADDU;
            {`SAU_FMT_D, `SAU_FN_ADD}: dec_op = sau_pkg::OP_ADDD;
            {`SAU_FMT_W, `SAU_FN_SUB}: dec_op = sau_pkg::OP_SUBW;
            {`SAU_FMT_U, `SAU_FN_SUB}: dec_op = sau_pkg::OP_SUBU;
            {`SAU_FMT_D, `SAU_FN_SUB}: dec_op = sau_pkg::OP_SUBD;
            {`SAU_FMT_OR, `SAU_FN_ADD}: dec_op = sau_pkg::OP_OR;
            {`SAU_FMT_U, `SAU_FN_SLL}: dec_op = sau_pkg::OP_SLL;
            default: dec_op = sau_pkg::OP_NOP;
         endcase
      end
   end

   // stage one: hold decoded op, present register addresses
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         iss_r <= '{op: sau_pkg::OP_NOP, fd: `SAU_RST_REG};
      end else begin
         iss_r.op <= dec_op;
         iss_r.fd <= INSTR_I[`SAU_FD_HI:`SAU_FD_LO];
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RF_RD_EN_O <= 1'b0;
         FS_ADDR_O <= `SAU_RST_REG;
         FT_ADDR_O <= `SAU_RST_REG;
      end else begin
         RF_RD_EN_O <= dec_op != sau_pkg::OP_NOP;
         FS_ADDR_O <= INSTR_I[`SAU_FS_HI:`SAU_FS_LO];
         FT_ADDR_O <= INSTR_I[`SAU_FT_HI:`SAU_FT_LO];
      end
   end

   // stage two: execute on read data
   always_comb begin
      mode.sub = iss_r.op inside {sau_pkg::OP_SUBW, sau_pkg::OP_SUBU, sau_pkg::OP_SUBD};
      mode.dbl = iss_r.op inside {sau_pkg::OP_ADDD, sau_pkg::OP_SUBD};
      mode.trap = iss_r.op inside {sau_pkg::OP_ADDW, sau_pkg::OP_ADDD,
                                   sau_pkg::OP_SUBW, sau_pkg::OP_SUBD};
   end

   sau_unpack #(.DW(DW)) u_unpack (
      .a_i(FS_DATA_I),
      .b_i(FT_DATA_I),
      .sel_i(iss_r.op),
      .res_o(unp_res)
   );

   // word forms rely on the caller keeping operands sign-extended
   sau_addsub #(.DW(DW)) u_addsub (
      .a_i(FS_DATA_I),
      .b_i(FT_DATA_I),
      .mode_i(mode),
      .res_o(ars_res),
      .ovf_o(ars_ovf)
   );

   // full 64-bit count compared, so huge counts also clear
   assign sll_w = FS_DATA_I[31:0] << FT_DATA_I[4:0];

   always_comb begin
      res_nxt = ars_res;
      ovf_nxt = 1'b0;
      vld_nxt = 1'b1;
      unique case (iss_r.op)
         sau_pkg::OP_NOP: vld_nxt = 1'b0;
         sau_pkg::OP_UPB, sau_pkg::OP_UPH, sau_pkg::OP_UPW: res_nxt = unp_res;
         sau_pkg::OP_ADDW, sau_pkg::OP_ADDD, sau_pkg::OP_SUBW, sau_pkg::OP_SUBD: begin
            ovf_nxt = ars_ovf;
            vld_nxt = !ars_ovf;
         end
         sau_pkg::OP_ADDU, sau_pkg::OP_SUBU: ovf_nxt = 1'b0;
         sau_pkg::OP_OR: res_nxt = FS_DATA_I | FT_DATA_I;
         sau_pkg::OP_SLL: begin
            if (FT_DATA_I >= `SAU_SLL_LIM) res_nxt = `SAU_RST_DATA;
            else res_nxt = sau_pkg::sau_sext_word(sll_w);
         end
      endcase
   end

   // a trapped op writes nothing; data bus keeps the last result
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         WB_VALID_O <= 1'b0;
         OVF_EXC_O <= 1'b0;
      end else begin
         WB_VALID_O <= vld_nxt;
         OVF_EXC_O <= ovf_nxt;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         WB_ADDR_O <= `SAU_RST_REG;
         WB_DATA_O <= `SAU_RST_DATA;
      end else if (vld_nxt) begin
         WB_ADDR_O <= iss_r.fd;
         WB_DATA_O <= res_nxt;
      end
   end

   // checking helpers: operands and op aligned with write back
   sau_pkg::sau_op_type op_q_r;
   logic [DW-1:0] fs_q_r;
   logic [DW-1:0] ft_q_r;
   logic [31:0] a_sw;
   logic [31:0] a_dw;
   logic [DW-1:0] a_sd;
   logic [DW-1:0] a_dd;
   logic [4:0] a_fd;
   logic a_done;

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         op_q_r <= sau_pkg::OP_NOP;
         fs_q_r <= `SAU_RST_DATA;
         ft_q_r <= `SAU_RST_DATA;
      end else begin
         op_q_r <= iss_r.op;
         fs_q_r <= FS_DATA_I;
         ft_q_r <= FT_DATA_I;
      end
   end

   assign a_sw = fs_q_r[31:0] + ft_q_r[31:0];
   assign a_dw = fs_q_r[31:0] - ft_q_r[31:0];
   assign a_sd = fs_q_r + ft_q_r;
   assign a_dd = fs_q_r - ft_q_r;
   assign a_fd = INSTR_I[`SAU_FD_HI:`SAU_FD_LO];
   assign a_done = WB_VALID_O || OVF_EXC_O;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_addw_issue;
      ISSUE_VALID_I && opc == `SAU_COPROCESSOR_TWO_OPCODE && fmt == `SAU_FMT_W && fn == `SAU_FN_ADD;
   endsequence
   sequence s_two_stage;
      ##1 RF_RD_EN_O ##1 (WB_VALID_O ^ OVF_EXC_O);
   endsequence

   property p_decode;
      s_addw_issue |-> s_two_stage;
   endproperty
   a_decode: assert property (p_decode) else $error("add word not completed in 2");

   property p_wb_addr;
      s_addw_issue |-> ##2 (OVF_EXC_O || WB_ADDR_O == $past(a_fd, 2));
   endproperty
   a_wb_addr: assert property (p_wb_addr) else $error("wrong write back register");

   property p_unpb;
      op_q_r == sau_pkg::OP_UPB |-> WB_VALID_O && !OVF_EXC_O
         && WB_DATA_O[15:0] == {ft_q_r[7:0], fs_q_r[7:0]}
         && WB_DATA_O[63:48] == {ft_q_r[31:24], fs_q_r[31:24]};
   endproperty
   a_unpb: assert property (p_unpb) else $error("byte unpack wrong");

   property p_unph;
      op_q_r == sau_pkg::OP_UPH |-> WB_DATA_O ==
         {ft_q_r[31:16], fs_q_r[31:16], ft_q_r[15:0], fs_q_r[15:0]};
   endproperty
   a_unph: assert property (p_unph) else $error("halfword unpack wrong");

   property p_unpw;
      op_q_r == sau_pkg::OP_UPW |-> WB_DATA_O == {ft_q_r[31:0], fs_q_r[31:0]};
   endproperty
   a_unpw: assert property (p_unpw) else $error("word unpack wrong");

   property p_zext;
      op_q_r == sau_pkg::OP_UPH && ft_q_r == `SAU_RST_DATA |->
         !OVF_EXC_O && WB_DATA_O[63:48] == '0 && WB_DATA_O[31:16] == '0;
   endproperty
   a_zext: assert property (p_zext) else $error("unpack not zero extended");

   property p_addw;
      op_q_r == sau_pkg::OP_ADDW && !OVF_EXC_O |->
         WB_VALID_O && WB_DATA_O == sau_pkg::sau_sext_word(a_sw);
   endproperty
   a_addw: assert property (p_addw) else $error("add word result wrong");

   property p_ovfw;
      op_q_r == sau_pkg::OP_ADDW |-> OVF_EXC_O ==
         (fs_q_r[31] == ft_q_r[31] && a_sw[31] != fs_q_r[31]);
   endproperty
   a_ovfw: assert property (p_ovfw) else $error("add word overflow wrong");

   property p_noupd;
      OVF_EXC_O |-> !WB_VALID_O && $stable(WB_DATA_O) && $past(RF_RD_EN_O);
   endproperty
   a_noupd: assert property (p_noupd) else $error("trap wrote a result");

   property p_addd;
      op_q_r == sau_pkg::OP_ADDD && !OVF_EXC_O |-> WB_DATA_O == a_sd;
   endproperty
   a_addd: assert property (p_addd) else $error("add double result wrong");

   property p_ovfd;
      op_q_r == sau_pkg::OP_SUBD |-> OVF_EXC_O ==
         (fs_q_r[63] != ft_q_r[63] && a_dd[63] != fs_q_r[63]);
   endproperty
   a_ovfd: assert property (p_ovfd) else $error("sub double overflow wrong");

   property p_subw;
      op_q_r == sau_pkg::OP_SUBW && !OVF_EXC_O |->
         WB_DATA_O == sau_pkg::sau_sext_word(a_dw);
   endproperty
   a_subw: assert property (p_subw) else $error("sub word result wrong");

   property p_subd;
      op_q_r == sau_pkg::OP_SUBD && !OVF_EXC_O |-> WB_VALID_O && WB_DATA_O == a_dd;
   endproperty
   a_subd: assert property (p_subd) else $error("sub double result wrong");

   property p_subu;
      op_q_r == sau_pkg::OP_SUBU |-> WB_VALID_O && !OVF_EXC_O
         && WB_DATA_O == sau_pkg::sau_sext_word(a_dw);
   endproperty
   a_subu: assert property (p_subu) else $error("unsigned sub word wrong");

   property p_addu;
      op_q_r == sau_pkg::OP_ADDU |-> a_done && !OVF_EXC_O
         && WB_DATA_O == sau_pkg::sau_sext_word(a_sw);
   endproperty
   a_addu: assert property (p_addu) else $error("unsigned add word wrong");

   property p_or;
      op_q_r == sau_pkg::OP_OR |-> WB_VALID_O && WB_DATA_O == (fs_q_r | ft_q_r);
   endproperty
   a_or: assert property (p_or) else $error("or result wrong");

   property p_sll;
      op_q_r == sau_pkg::OP_SLL && ft_q_r < `SAU_SLL_LIM |->
         WB_DATA_O[31:0] == fs_q_r[31:0] << ft_q_r[4:0]
         && WB_DATA_O[63:32] == {32{WB_DATA_O[31]}};
   endproperty
   a_sll: assert property (p_sll) else $error("shift left wrong");

   property p_sll_big;
      op_q_r == sau_pkg::OP_SLL && ft_q_r >= `SAU_SLL_LIM |->
         WB_VALID_O && WB_DATA_O == `SAU_RST_DATA;
   endproperty
   a_sll_big: assert property (p_sll_big) else $error("big shift not zero");
endmodule : sau_simd_unit

// ===== dv/sau_rf_model.sv
// media register file stand-in for the unpack/add/sub unit
// assumes: read data is wanted while the read strobe is high
`timescale 1ns/10ps
module sau_rf_model (
   // clock
   input wire logic clk_i,
   // read side, from the unit
   input wire logic rd_en_i,
   input wire logic [4:0] fs_addr_i,
   input wire logic [4:0] ft_addr_i,
   // preload side, from the bench
   input wire logic wr_en_i,
   input wire logic [4:0] wr_fs_addr_i,
   input wire logic [4:0] wr_ft_addr_i,
   input wire logic [63:0] wr_fs_data_i,
   input wire logic [63:0] wr_ft_data_i,
   // read data
   output logic [63:0] fs_data_o,
   output logic [63:0] ft_data_o
);
   logic [63:0] mem_r [32];
   logic [63:0] last_fs_r = 64'h0;
   logic [63:0] last_ft_r = 64'h0;

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_r[wr_fs_addr_i] <= wr_fs_data_i;
         mem_r[wr_ft_addr_i] <= wr_ft_data_i;
      end
      if (rd_en_i) begin
         last_fs_r <= fs_data_o;
         last_ft_r <= ft_data_o;
      end
   end

   // outside a read the bus shows the inverse, so stale data never matches
   always_comb begin
      fs_data_o = rd_en_i ? mem_r[fs_addr_i] : ~last_fs_r;
      ft_data_o = rd_en_i ? mem_r[ft_addr_i] : ~last_ft_r;
   end
endmodule : sau_rf_model

// ===== dv/sau_simd_unit_test.sv
// self-checking bench for the media unpack/add/sub/or/shift unit
// assumes: register file model answers in the cycle of the read strobe
`timescale 1ns/10ps
`include "sau_params.svh"
module sau_simd_unit_test;
   logic CLK_I = 1'b0;
   logic RST_N_I = 1'b0;
   logic ISSUE_VALID_I = 1'b0;
   logic [31:0] INSTR_I = 32'h0;
   logic RF_RD_EN_O, WB_VALID_O, OVF_EXC_O;
   logic [4:0] FS_ADDR_O, FT_ADDR_O, WB_ADDR_O;
   logic [63:0] FS_DATA_I, FT_DATA_I, WB_DATA_O;
   logic wr_en = 1'b0;
   logic [4:0] wr_fs = 5'h0;
   logic [4:0] wr_ft = 5'h0;
   logic [63:0] wr_a = 64'h0;
   logic [63:0] wr_b = 64'h0;
   logic [63:0] rng = 64'h2d54;
   logic [63:0] a, b;
   logic [69:0] exp_q[$];
   logic [9:0] adr_q[$];
   logic [63:0] last_data = 64'h0;
   logic [4:0] last_addr = 5'h0;
   int mismatches = 0;
   int checks = 0;
   int n = 0;
   int k;
   logic [4:0] fmt_t [11] = '{`SAU_FMT_UPB, `SAU_FMT_UPH, `SAU_FMT_UPW, `SAU_FMT_W,
      `SAU_FMT_U, `SAU_FMT_D, `SAU_FMT_W, `SAU_FMT_U, `SAU_FMT_D, `SAU_FMT_OR, `SAU_FMT_U};
   logic [5:0] fn_t [11] = '{`SAU_FN_UPK, `SAU_FN_UPK, `SAU_FN_UPW, `SAU_FN_ADD,
      `SAU_FN_ADD, `SAU_FN_ADD, `SAU_FN_SUB, `SAU_FN_SUB, `SAU_FN_SUB, `SAU_FN_ADD, `SAU_FN_SLL};

   sau_simd_unit #(.DW(64), .RAW(5)) sau_simd_unit_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
      .ISSUE_VALID_I(ISSUE_VALID_I), .INSTR_I(INSTR_I), .RF_RD_EN_O(RF_RD_EN_O),
      .FS_ADDR_O(FS_ADDR_O), .FT_ADDR_O(FT_ADDR_O), .FS_DATA_I(FS_DATA_I),
      .FT_DATA_I(FT_DATA_I), .WB_VALID_O(WB_VALID_O), .WB_ADDR_O(WB_ADDR_O),
      .WB_DATA_O(WB_DATA_O), .OVF_EXC_O(OVF_EXC_O));

   sau_rf_model sau_rf_model_inst (.clk_i(CLK_I), .rd_en_i(RF_RD_EN_O),
      .fs_addr_i(FS_ADDR_O), .ft_addr_i(FT_ADDR_O), .wr_en_i(wr_en),
      .wr_fs_addr_i(wr_fs), .wr_ft_addr_i(wr_ft), .wr_fs_data_i(wr_a),
      .wr_ft_data_i(wr_b), .fs_data_o(FS_DATA_I), .ft_data_o(FT_DATA_I));

   always #10 CLK_I = ~CLK_I;

   function automatic logic [63:0] xs(input logic [63:0] x);
      logic [63:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 7);
      xs = y ^ (y << 17);
   endfunction : xs

   function automatic logic [63:0] sx(input logic [31:0] w);
      sx = {{32{w[31]}}, w};
   endfunction : sx

   // returns {trap, result}
   function automatic logic [64:0] model(input int k, input logic [63:0] a, input logic [63:0] b);
      logic [64:0] s;
      logic [32:0] w;
      case (k)
         0: model = {1'b0, b[31:24], a[31:24], b[23:16], a[23:16], b[15:8], a[15:8], b[7:0], a[7:0]};
         1: model = {1'b0, b[31:16], a[31:16], b[15:0], a[15:0]};
         2: model = {1'b0, b[31:0], a[31:0]};
         3, 4, 6, 7: begin
            w = (k < 6) ? {a[31], a[31:0]} + {b[31], b[31:0]} : {a[31], a[31:0]} - {b[31], b[31:0]};
            model = {(k == 3 || k == 6) && (w[32] ^ w[31]), sx(w[31:0])};
         end
         5, 8: begin
            s = (k == 5) ? {a[63], a} + {b[63], b} : {a[63], a} - {b[63], b};
            model = {s[64] ^ s[63], s[63:0]};
         end
         9: model = {1'b0, a | b};
         default: begin
            w = {1'b0, a[31:0] << b[4:0]};
            model = (b >= 64'h20) ? 65'h0 : {1'b0, sx(w[31:0])};
         end
      endcase
   endfunction : model

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic issue(input int k, input logic [63:0] a, input logic [63:0] b);
      logic [4:0] fd, fs;
      logic [64:0] r;
      rng = xs(rng);
      fd = rng[4:0];
      fs = 5'((2 * n) % 32);
      n++;
      r = model(k, a, b);
      @(posedge CLK_I);
      ISSUE_VALID_I <= 1'b1;
      INSTR_I <= {`SAU_COPROCESSOR_TWO_OPCODE, fmt_t[k], fs + 5'h1, fs, fd, fn_t[k]};
      wr_en <= 1'b1;
      wr_fs <= fs;
      wr_ft <= fs + 5'h1;
      wr_a <= a;
      wr_b <= b;
      exp_q.push_back({r[64], fd, r[63:0]});
      adr_q.push_back({fs, fs + 5'h1});
   endtask : issue

   task automatic raw(input logic v, input logic [31:0] w);
      @(posedge CLK_I);
      ISSUE_VALID_I <= v;
      INSTR_I <= w;
      wr_en <= 1'b0;
   endtask : raw

   task automatic drain;
      int i;
      raw(1'b0, 32'h0);
      for (i = 0; i < 20 && (exp_q.size() != 0 || adr_q.size() != 0); i++) @(posedge CLK_I);
      chk("pending", 64'h0, 64'(exp_q.size() + adr_q.size()));
   endtask : drain

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   // results appear one edge apart, so sample half a cycle later
   always @(negedge CLK_I) begin
      logic [69:0] e;
      if (RST_N_I) begin
         if (RF_RD_EN_O !== 1'b0) begin
            if (adr_q.size() == 0) chk("read_extra", 64'h0, 64'h1);
            else chk("read_addr", 64'(adr_q.pop_front()), 64'({FS_ADDR_O, FT_ADDR_O}));
         end
         if (WB_VALID_O !== 1'b0 || OVF_EXC_O !== 1'b0) begin
            if (exp_q.size() == 0) chk("result_extra", 64'h0, 64'h1);
            else begin
               e = exp_q.pop_front();
               chk("ovf_wb", 64'({e[69], ~e[69]}), 64'({OVF_EXC_O, WB_VALID_O}));
               if (!e[69]) begin
                  last_data = e[63:0];
                  last_addr = e[68:64];
               end
               chk("wb_addr", 64'(last_addr), 64'(WB_ADDR_O));
               chk("wb_data", last_data, WB_DATA_O);
            end
         end
      end
   end

   initial begin
      #1000000;
      mismatches++;
      end_sim;
   end

   initial begin
      repeat (3) @(posedge CLK_I);
      @(negedge CLK_I);
      chk("reset_out", 64'h0, 64'({RF_RD_EN_O, WB_VALID_O, OVF_EXC_O, WB_ADDR_O, FS_ADDR_O}));
      chk("reset_data", 64'h0, WB_DATA_O);
      @(posedge CLK_I);
      RST_N_I <= 1'b1;
      for (int i = 0; i < 88; i++) begin
         rng = xs(rng);
         a = rng;
         rng = xs(rng);
         b = rng;
         k = i % 11;
         if (k inside {3, 4, 6, 7}) begin
            a = sx(a[31:0]);
            b = sx(b[31:0]);
         end
         if (k == 10 && i % 2 == 1) b = {59'h0, b[4:0]};
         issue(k, a, b);
      end
      issue(3, 64'h7fffffff, 64'h1);
      issue(3, 64'hffffffff80000000, 64'hffffffffffffffff);
      issue(4, 64'h7fffffff, 64'h1);
      issue(6, 64'hffffffff80000000, 64'h1);
      issue(7, 64'hffffffff80000000, 64'h1);
      issue(5, 64'h7fffffffffffffff, 64'h1);
      issue(8, 64'h8000000000000000, 64'h1);
      issue(5, 64'hfffffffffffffffe, 64'h1);
      issue(8, 64'h0, 64'h7fffffffffffffff);
      for (int j = 0; j < 3; j++) issue(j, xs(rng + j), 64'h0);
      issue(10, 64'h1, 64'h1f);
      issue(10, 64'hffffffff, 64'h20);
      issue(10, 64'h1, 64'h100000000);
      drain();
      raw(1'b1, {6'h11, `SAU_FMT_W, 15'h0, `SAU_FN_ADD});
      raw(1'b1, {`SAU_COPROCESSOR_TWO_OPCODE, `SAU_FMT_W, 15'h0, 6'h3f});
      raw(1'b0, {`SAU_COPROCESSOR_TWO_OPCODE, `SAU_FMT_W, 15'h0, `SAU_FN_ADD});
      issue(9, 64'hf0f0, 64'h0f0f0000);
      drain();
      end_sim;
   end
endmodule : sau_simd_unit_test
